//--- cfe_alu.sv
// Eight-bit ALU with status flag outputs
`timescale 1ns/1ps
`include "cfe_defines.svh"
module cfe_alu
    import cfe_pkg::*;
(
    input  wire logic [3:0] op,
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic [3:0] st_in,
    output logic      [7:0] res,
    output logic      [3:0] st_out,
    output logic      [3:0] st_we
);
    // Adder returning {ov, ac, c, sum}
    function automatic logic [10:0] add_f(input logic [7:0] x,
                                          input logic [7:0] y,
                                          input logic       ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
        h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
        add_f = {(x[7] == y[7]) && (s[7] != x[7]), h[4], s[8], s[7:0]};
    endfunction : add_f

    logic       cin;
    logic       acin;
    logic       lo_adj;
    logic       hi_adj;
    logic [8:0] d1;
    logic [8:0] d2;
    logic [10:0] ar;
    assign cin  = st_in[`CFE_ST_C];
    assign acin = st_in[`CFE_ST_AC];

    // Decimal adjust of the accumulator
    assign lo_adj = (a[3:0] > 4'h9) || acin;
    assign d1     = {1'b0, a} + (lo_adj ? 9'h006 : 9'h000);
    assign hi_adj = (d1[7:4] > 4'h9) || cin || d1[8];
    assign d2     = d1 + (hi_adj ? 9'h060 : 9'h000);

    // Operation select and flag masks
    always_comb
    begin
        ar     = {3'h0, b};
        st_we  = `CFE_FW_Z;
        st_out = st_in;
        case (cfe_alu_t'(op))
            ALU_ADD: begin ar = add_f(a, b, 1'b0); st_we = `CFE_FW_ALL; end
            ALU_ADC: begin ar = add_f(a, b, cin); st_we = `CFE_FW_ALL; end
            ALU_SUB: begin ar = add_f(a, ~b, 1'b1); st_we = `CFE_FW_ALL; end
            ALU_SBC: begin ar = add_f(a, ~b, cin); st_we = `CFE_FW_ALL; end
            ALU_DAA: begin ar = {1'b0, acin, hi_adj, d2[7:0]};
                     st_we = `CFE_FW_C; end
            ALU_AND: ar = {3'h0, a & b};
            ALU_OR:  ar = {3'h0, a | b};
            ALU_XOR: ar = {3'h0, a ^ b};
            ALU_CPL: ar = {3'h0, ~b};
            ALU_RR:  begin ar = {3'h0, b[0], b[7:1]}; st_we = `CFE_FW_NONE; end
            ALU_RRC: begin ar = {2'h0, b[0], cin, b[7:1]}; st_we = `CFE_FW_C; end
            ALU_RL:  begin ar = {3'h0, b[6:0], b[7]}; st_we = `CFE_FW_NONE; end
            ALU_RLC: begin ar = {2'h0, b[7], b[6:0], cin}; st_we = `CFE_FW_C; end
            ALU_INC: ar = add_f(b, 8'h00, 1'b1);
            ALU_DEC: ar = add_f(b, 8'hff, 1'b0);
            default: begin ar = {3'h0, b}; st_we = `CFE_FW_NONE; end
        endcase
        res                = ar[7:0];
        st_out[`CFE_ST_C]  = ar[8];
        st_out[`CFE_ST_AC] = ar[9];
        st_out[`CFE_ST_OV] = ar[10];
        st_out[`CFE_ST_Z]  = (ar[7:0] == 8'h00);
    end
endmodule : cfe_alu

//--- cfe_core.sv
// Instruction sequencer: phases, overlapped fetch, PC, stack and ALU
//
// Notes on behaviour
// - Clock split into four phases; one pass is one instruction cycle.
// - PC advances and a word is fetched at T1; T2-T4 execute.
// - Next fetch overlaps current execution; one instruction per cycle.
// - Jumps and calls take two cycles: target, then branch.
// - Sequential PC increases by one, pointing at the next instruction.
// - Only PC bits 7:0 are visible to software, read and write.
// - PC is 11 or 12 bits; the low byte is bits 7:0.
// - Jump, call, interrupt and reset load the PC directly.
// - A true skip discards the prefetched word and runs a dummy cycle.
// - Writing the PC low byte jumps within the current 256-word page.
// - Writing the PC low byte inserts one dummy cycle.
// - Return stack holds PCs only and is hidden from software.
// - Call and interrupt acknowledge push the PC; returns pop it.
// - Reset sets the stack pointer to the top level.
// - Full stack withholds interrupt acknowledge until a return frees it.
// - A call on a full stack runs and loses the oldest entry.
// - Eight-bit ALU through the accumulator, result to chosen register.
// - ALU flags update together with the result write.
// - Add, subtract, decimal adjust, logic, rotates, increment, decrement.
// - ALU supplies the zero decision for skips; jumps, calls and returns are unconditional.
`timescale 1ns/1ps
`include "cfe_defines.svh"
module cfe_core
    import cfe_pkg::*;
#(
    parameter int PC_W        = 12,
    parameter int STACK_DEPTH = `CFE_STACK_DEPTH
) (
    input  wire logic            clk,
    input  wire logic            sys_rst,
    output logic      [PC_W-1:0] pm_addr,
    input  wire logic [15:0]     pm_rdata,
    output logic      [7:0]      dm_addr,
    output logic      [7:0]      dm_wdata,
    output logic                 dm_we,
    input  wire logic [7:0]      dm_rdata,
    input  wire logic            irq_pending,
    output logic                 int_ack,
    output logic                 int_return,
    output logic      [3:0]      cycle_phases,
    output logic      [7:0]      acc,
    output logic      [3:0]      status
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cfe_phase_t       phase_reg;
    cfe_phase_t       phase_next;
    logic [3:0]       onehot_reg;
    logic [PC_W-1:0]  pc_reg;
    logic [PC_W-1:0]  pc_next;
    logic [15:0]      ir_reg;
    logic [7:0]       acc_reg;
    logic [3:0]       st_reg;
    logic [7:0]       dma_reg;
    logic [7:0]       dmw_reg;
    logic             dmwe_reg;
    logic             ack_reg;
    logic             interrupt_return_reg;

    // ------------------------------------------------------------
    // Phase generator
    // ------------------------------------------------------------

    // Gray sequence T1, T2, T3, T4, back to T1
    always_comb
    begin
        case (phase_reg)
            PH_T1:   phase_next = PH_T2;
            PH_T2:   phase_next = PH_T3;
            PH_T3:   phase_next = PH_T4;
            PH_T4:   phase_next = PH_T1;
            default: phase_next = PH_T1;
        endcase
    end

    // One-cycle enables derived from the phase
    logic cyc_end;
    logic t1_end;
    assign cyc_end = (phase_reg == PH_T4);
    assign t1_end  = (phase_reg == PH_T1);

    // Phase counter and its one-hot view
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            phase_reg  <= PH_T1;
            onehot_reg <= 4'h1;
        end
        else
        begin
            phase_reg  <= phase_next;
            onehot_reg <= {onehot_reg[2:0], onehot_reg[3]};
        end
    end

    // ------------------------------------------------------------
    // Decode of the executing word
    // ------------------------------------------------------------
    cfe_op_t         op;
    logic [3:0]      aop;
    logic [7:0]      fld;
    logic [PC_W-1:0] tgt;
    assign op  = cfe_op_t'(ir_reg[15:12]);
    assign aop = ir_reg[11:8];
    assign fld = ir_reg[7:0];
    assign tgt = ir_reg[PC_W-1:0];

    // Instruction class strobes
    logic is_alui;
    logic is_alum;
    logic is_alua;
    logic is_jmp;
    logic is_call;
    logic is_ret;
    logic is_interrupt_return;
    logic is_sz;
    logic is_snz;
    logic is_siz;
    logic is_sdz;
    logic is_movm;
    logic is_mova;
    assign is_alui = (op == OP_ALUI);
    assign is_alum = (op == OP_ALUM);
    assign is_alua = (op == OP_ALUA);
    assign is_jmp  = (op == OP_JMP);
    assign is_call = (op == OP_CALL);
    assign is_ret  = (op == OP_RET);
    assign is_interrupt_return = (op == OP_INTERRUPT_RETURN);
    assign is_sz   = (op == OP_SZ);
    assign is_snz  = (op == OP_SNZ);
    assign is_siz  = (op == OP_SIZ);
    assign is_sdz  = (op == OP_SDZ);
    assign is_movm = (op == OP_MOVM);
    assign is_mova = (op == OP_MOVA);

    // ------------------------------------------------------------
    // Operand fetch and ALU
    // ------------------------------------------------------------

    // Low PC byte stands in for memory at its alias address
    logic       pcl_sel;
    logic [7:0] mem_val;
    assign pcl_sel = (fld == `CFE_PCL_ADDR);
    assign mem_val = pcl_sel ? pc_reg[7:0] : dm_rdata;

    // ALU operand and operation selection
    logic [7:0] alu_b;
    logic [3:0] alu_op;
    assign alu_b  = is_alui ? fld : mem_val;
    assign alu_op = is_siz ? ALU_INC :
                    is_sdz ? ALU_DEC :
                    (is_alui || is_alum || is_alua) ? aop : ALU_PASS;

    logic [7:0] alu_res;
    logic [3:0] alu_st;
    logic [3:0] alu_we;

    // Arithmetic, logic, rotate, adjust and step unit
    cfe_alu u_alu (
        .op     (alu_op),
        .a      (acc_reg),
        .b      (alu_b),
        .st_in  (st_reg),
        .res    (alu_res),
        .st_out (alu_st),
        .st_we  (alu_we)
    );

    // ------------------------------------------------------------
    // Write-back decisions
    // ------------------------------------------------------------
    logic       alu_cls;
    logic       acc_wr;
    logic       mem_wr;
    logic [7:0] wr_data;
    logic       pcl_wr;
    assign alu_cls = is_alui || is_alum || is_alua;
    assign acc_wr  = is_alui || is_alua || is_movm;
    assign mem_wr  = is_alum || is_siz || is_sdz || is_mova;
    assign wr_data = is_mova ? acc_reg : alu_res;
    assign pcl_wr  = mem_wr && pcl_sel;

    // Skip decisions taken from the ALU zero result
    logic res_zero;
    logic skip;
    assign res_zero = alu_st[`CFE_ST_Z];
    assign skip = ((is_sz || is_siz || is_sdz) && res_zero) ||
                  (is_snz && !res_zero);

    // ------------------------------------------------------------
    // Return stack and interrupt entry
    // ------------------------------------------------------------
    logic [PC_W-1:0] stk_top;
    logic            stk_full;
    logic            redirect;
    logic            take_int;
    logic            push;
    logic            pop;

    // Flow changes decided this cycle
    assign redirect = is_jmp || is_call || is_ret || is_interrupt_return || pcl_wr;

    // Interrupt waits while the stack has no free level
    assign take_int = irq_pending && !stk_full && !redirect && !skip;
    assign push = cyc_end && (is_call || take_int);
    assign pop  = cyc_end && (is_ret || is_interrupt_return);

    // Hidden return-address storage, not mapped anywhere
    cfe_ret_stack #(
        .W     (PC_W),
        .DEPTH (STACK_DEPTH)
    ) u_stack (
        .clk     (clk),
        .sys_rst (sys_rst),
        .push    (push),
        .pop     (pop),
        .din     (pc_reg),
        .top     (stk_top),
        .full    (stk_full),
        .empty   ()
    );

    // ------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------

    // Next PC: load on flow change, else step by one
    always_comb
    begin
        if (is_jmp || is_call)
            pc_next = tgt;
        else if (is_ret || is_interrupt_return)
            pc_next = stk_top;
        else if (pcl_wr)
            pc_next = {pc_reg[PC_W-1:8], wr_data};
        else if (take_int)
            pc_next = PC_W'(`CFE_INT_VEC);
        else
            pc_next = pc_reg + 1'b1;
    end

    // Prefetched word is discarded on any flow change
    logic discard;
    assign discard = redirect || skip || take_int;

    // PC and instruction register move at the start of T1
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pc_reg <= PC_W'(`CFE_RESET_VEC);
            ir_reg <= `CFE_NOP_WORD;
        end
        else if (cyc_end)
        begin
            pc_reg <= pc_next;
            ir_reg <= discard ? `CFE_NOP_WORD : pm_rdata;
        end
    end

    // ------------------------------------------------------------
    // Accumulator and status
    // ------------------------------------------------------------

    // Result and flags land on the same edge
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            acc_reg <= 8'h00;
            st_reg  <= 4'h0;
        end
        else if (cyc_end)
        begin
            if (acc_wr)
                acc_reg <= alu_res;
            if (alu_cls)
                st_reg <= (st_reg & ~alu_we) | (alu_st & alu_we);
        end
    end

    // ------------------------------------------------------------
    // Data memory port
    // ------------------------------------------------------------

    // Address set at T2, write pulse issued at start of T1
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            dma_reg  <= 8'h00;
            dmw_reg  <= 8'h00;
            dmwe_reg <= 1'b0;
        end
        else
        begin
            if (t1_end)
                dma_reg <= fld;
            if (cyc_end)
                dmw_reg <= wr_data;
            dmwe_reg <= cyc_end && mem_wr && !pcl_sel;
        end
    end

    // ------------------------------------------------------------
    // Interrupt handshake pulses
    // ------------------------------------------------------------

    // One-cycle acknowledge and return marks for the controller
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ack_reg  <= 1'b0;
            interrupt_return_reg <= 1'b0;
        end
        else
        begin
            ack_reg  <= cyc_end && take_int;
            interrupt_return_reg <= cyc_end && is_interrupt_return;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign pm_addr      = pc_reg;
    assign dm_addr      = dma_reg;
    assign dm_wdata     = dmw_reg;
    assign dm_we        = dmwe_reg;
    assign int_ack      = ack_reg;
    assign int_return   = interrupt_return_reg;
    assign cycle_phases = onehot_reg;
    assign acc          = acc_reg;
    assign status       = st_reg;
endmodule : cfe_core

//--- cfe_core_assertions.sv
// Port-level checks for the sequencer core
`timescale 1ns/1ps
`include "cfe_defines.svh"
module cfe_core_assertions
    import cfe_pkg::*;
#(
    parameter int PC_W        = 12,
    parameter int STACK_DEPTH = 6
) (
    input wire logic            clk,
    input wire logic            sys_rst,
    input wire logic [PC_W-1:0] pm_addr,
    input wire logic [15:0]     pm_rdata,
    input wire logic [7:0]      dm_addr,
    input wire logic [7:0]      dm_wdata,
    input wire logic            dm_we,
    input wire logic [7:0]      dm_rdata,
    input wire logic            irq_pending,
    input wire logic            int_ack,
    input wire logic            int_return,
    input wire logic [3:0]      cycle_phases,
    input wire logic [7:0]      acc,
    input wire logic [3:0]      status
);
    // Phase vector advanced by one step
    logic [3:0] rot;
    assign rot = {cycle_phases[2:0], cycle_phases[3]};

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // --------
    // Phases and fetch
    // --------
    AST_PHASE_ONEHOT: assert property ($onehot(cycle_phases))
        else $error("phase vector not one-hot");
    AST_PHASE_ROTATE: assert property (
        cycle_phases != 4'h0 |=> cycle_phases == $past(rot))
        else $error("phase did not advance by one");
    AST_FETCH_T1: assert property (
        !cycle_phases[0] |-> $stable(pm_addr))
        else $error("fetch address moved outside first phase");
    AST_FETCH_ADVANCE: assert property (
        cycle_phases[3] |=> pm_addr != $past(pm_addr))
        else $error("no new fetch at start of cycle");
    AST_RESET_STATE: assert property (
        $fell(sys_rst) |-> pm_addr == PC_W'(`CFE_RESET_VEC)
            && cycle_phases == 4'h1 && acc == 8'h00 && status == 4'h0)
        else $error("state after reset wrong");

    // --------
    // Interrupt entry and return
    // --------
    AST_ACK_VECTOR: assert property (
        int_ack |-> cycle_phases == 4'h1 && pm_addr == PC_W'(`CFE_INT_VEC))
        else $error("ack without vector load");
    AST_ACK_SPACING: assert property (
        int_ack |=> !int_ack [*3])
        else $error("ack longer than one phase");
    AST_ACK_CAUSE: assert property (
        $rose(int_ack) |-> $past(irq_pending))
        else $error("ack without pending request");
    AST_RET_PULSE: assert property (
        int_return |-> cycle_phases == 4'h1 ##1 !int_return)
        else $error("return pulse misplaced");

    // --------
    // Data writes
    // --------
    AST_PCL_NO_WE: assert property (
        dm_we |-> dm_addr != `CFE_PCL_ADDR && cycle_phases == 4'h1)
        else $error("write strobe on low byte alias");
endmodule : cfe_core_assertions

bind cfe_core cfe_core_assertions #(
    .PC_W       (PC_W),
    .STACK_DEPTH(STACK_DEPTH)
) i_chk (
    .clk, .sys_rst, .pm_addr, .pm_rdata, .dm_addr, .dm_wdata, .dm_we,
    .dm_rdata, .irq_pending, .int_ack, .int_return, .cycle_phases,
    .acc, .status
);

//--- cfe_core_tb.sv
// Self-checking bench for the sequencer core
`timescale 1ns/1ps
module cfe_core_tb
    import cfe_pkg::*;
;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        irq_pending = 1'b0;
    logic [7:0]  dm_val = 8'h00;
    logic [11:0] pm_addr;
    logic [15:0] pm_rdata;
    logic [7:0]  dm_addr;
    logic [7:0]  dm_wdata;
    logic        dm_we;
    logic        int_ack;
    logic        int_return;
    logic [3:0]  cycle_phases;
    logic [7:0]  acc;
    logic [3:0]  status;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    // ALU steps: operation, operand, result, flags
    localparam logic [23:0] ALU_TAB [16] = '{
        24'h005050, 24'h0fb007, 24'h101020, 24'h203ff0,
        24'h300fe3, 24'h681ff3, 24'h581813, 24'hb81033,
        24'h903813, 24'hc81033, 24'ha03813, 24'h781007,
        24'h80ff03, 24'hdff007, 24'he01007, 24'h400667};
    // Skip tests: opcode, memory byte, skip taken
    localparam logic [15:0] SK_TAB [8] = '{
        16'h8001, 16'h8050, 16'h9000, 16'h9051,
        16'haff1, 16'ha050, 16'hb011, 16'hb050};
    localparam logic [11:0] BR_TRACE [8] = '{
        12'h000, 12'h001, 12'h020, 12'h021,
        12'h030, 12'h031, 12'h021, 12'h022};

    // 25 MHz clock
    always #20 clk = ~clk;

    cfe_core #(
        .PC_W       (12),
        .STACK_DEPTH(2)
    ) i_dut (
        .clk, .sys_rst, .pm_addr, .pm_rdata, .dm_addr, .dm_wdata, .dm_we,
        .dm_rdata(dm_val), .irq_pending, .int_ack, .int_return,
        .cycle_phases, .acc, .status
    );

    cfe_pm_model #(
        .AW(12)
    ) i_pm (
        .addr (pm_addr),
        .rdata(pm_rdata)
    );

    // Cycle ceiling against a hung run
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    // --------
    // Shared tasks
    // --------
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Hold reset three cycles with program memory cleared
    task automatic boot();
        @(negedge clk);
        sys_rst = 1'b1;
        irq_pending = 1'b0;
        for (int i = 0; i < 4096; i++)
            i_pm.mem[i] = 16'h0000;
        repeat (3) @(negedge clk);
    endtask : boot

    task automatic go(input int n);
        repeat (4 * n) @(negedge clk);
    endtask : go

    // --------
    // Scenarios
    // --------
    task automatic t_seq();
        boot();
        sys_rst = 1'b0;
        for (int k = 0; k < 4; k++)
            for (int j = 0; j < 4; j++)
            begin
                check(pm_addr, 16'(k));
                check(cycle_phases, 16'h1 << j);
                @(negedge clk);
            end
        $display("test seq done");
    endtask : t_seq

    task automatic t_alu();
        boot();
        for (int i = 0; i < 16; i++)
            i_pm.mem[i] = {OP_ALUI, ALU_TAB[i][23:12]};
        sys_rst = 1'b0;
        go(2);
        for (int i = 0; i < 16; i++)
        begin
            check(acc, ALU_TAB[i][11:4]);
            check(status, ALU_TAB[i][3:0]);
            go(1);
        end
        $display("test alu done");
    endtask : t_alu

    task automatic t_branch();
        boot();
        i_pm.mem[0] = {OP_JMP, 12'h020};
        i_pm.mem[1] = {OP_ALUI, ALU_ADD, 8'h11};
        i_pm.mem[12'h020] = {OP_CALL, 12'h030};
        i_pm.mem[12'h021] = {OP_ALUI, ALU_ADD, 8'h01};
        i_pm.mem[12'h030] = {OP_RET, 12'h000};
        sys_rst = 1'b0;
        for (int k = 0; k < 8; k++)
        begin
            check(pm_addr, BR_TRACE[k]);
            go(1);
        end
        go(1);
        check(acc, 16'h01);
        $display("test branch done");
    endtask : t_branch

    task automatic t_skip();
        logic [15:0] sk;
        logic [7:0]  exp_w;
        for (int i = 0; i < 8; i++)
        begin
            sk = SK_TAB[i];
            exp_w = (sk[15:12] == 4'ha) ? sk[11:4] + 8'h01 :
                    (sk[15:12] == 4'hb) ? sk[11:4] - 8'h01 : 8'h00;
            boot();
            dm_val = sk[11:4];
            i_pm.mem[0] = {sk[15:12], 4'h0, 8'h10};
            i_pm.mem[1] = {OP_ALUI, ALU_ADD, 8'h11};
            i_pm.mem[2] = {OP_ALUI, ALU_ADD, 8'h22};
            sys_rst = 1'b0;
            go(2);
            check(dm_addr, 16'h10);
            check(dm_we, 16'(sk[13]));
            if (sk[13])
                check(dm_wdata, exp_w);
            go(4);
            check(acc, sk[0] ? 16'h22 : 16'h33);
        end
        $display("test skip done");
    endtask : t_skip

    task automatic t_pcl();
        boot();
        i_pm.mem[0] = {OP_JMP, 12'h105};
        i_pm.mem[12'h105] = {OP_ALUI, ALU_ADD, 8'h40};
        i_pm.mem[12'h106] = {OP_MOVA, 4'h0, 8'h06};
        i_pm.mem[12'h107] = {OP_ALUI, ALU_ADD, 8'h80};
        i_pm.mem[12'h140] = {OP_MOVM, 4'h0, 8'h06};
        i_pm.mem[12'h141] = {OP_ALUA, ALU_ADD, 8'h10};
        i_pm.mem[12'h142] = {OP_ALUM, ALU_SUB, 8'h10};
        dm_val = 8'h05;
        sys_rst = 1'b0;
        go(5);
        check(pm_addr, 16'h140);
        go(1);
        check(acc, 16'h40);
        go(1);
        check(acc, 16'h41);
        go(1);
        check(acc, 16'h46);
        go(1);
        check(dm_we, 16'h1);
        check(dm_wdata, 16'h41);
        check(status, 16'h3);
        $display("test pcl done");
    endtask : t_pcl

    task automatic t_irq();
        int n = 0;
        boot();
        i_pm.mem[0] = {OP_CALL, 12'h020};
        i_pm.mem[12'h020] = {OP_CALL, 12'h030};
        i_pm.mem[12'h034] = {OP_RET, 12'h000};
        i_pm.mem[12'h004] = {OP_INTERRUPT_RETURN, 12'h000};
        sys_rst = 1'b0;
        go(6);
        irq_pending = 1'b1;
        // Stack full: request must wait for the return
        for (int i = 0; i < 12; i++)
        begin
            @(negedge clk);
            if (int_ack === 1'b1)
                n++;
        end
        check(16'(n), 16'h0);
        n = 0;
        while (int_ack !== 1'b1 && n < 16)
        begin
            @(negedge clk);
            n++;
        end
        check(int_ack, 16'h1);
        check(pm_addr, 16'h004);
        irq_pending = 1'b0;
        n = 0;
        while (int_return !== 1'b1 && n < 24)
        begin
            @(negedge clk);
            n++;
        end
        check(int_return, 16'h1);
        check(pm_addr, 16'h021);
        $display("test irq done");
    endtask : t_irq

    // Main sequence
    initial
    begin
        t_seq();
        t_alu();
        t_branch();
        t_skip();
        t_pcl();
        t_irq();
        give_verdict();
    end
endmodule : cfe_core_tb

//--- cfe_defines.svh
// Constants for the fetch, execute and return-stack core
`ifndef CFE_DEFINES_SVH
`define CFE_DEFINES_SVH
// Data address that aliases the program counter low byte
`define CFE_PCL_ADDR     8'h06
// Program counter values loaded by reset and interrupt entry
`define CFE_RESET_VEC    12'h000
`define CFE_INT_VEC      12'h004
// Word executed in a dummy cycle
`define CFE_NOP_WORD     16'h0000
// Default number of return-stack levels
`define CFE_STACK_DEPTH  6
// Status bit positions
`define CFE_ST_C         0
`define CFE_ST_AC        1
`define CFE_ST_Z         2
`define CFE_ST_OV        3
// Flag write masks
`define CFE_FW_NONE      4'h0
`define CFE_FW_ALL       4'hf
`define CFE_FW_Z         4'h4
`define CFE_FW_C         4'h1
`endif

//--- cfe_pkg.sv
// Types for the fetch, execute and return-stack core
package cfe_pkg;
    // Instruction phases, Gray coded along CYCLE_PHASES
    typedef enum logic [1:0] {
        PH_T1 = 2'h0,
        PH_T2 = 2'h1,
        PH_T3 = 2'h3,
        PH_T4 = 2'h2
    } cfe_phase_t;

    // Instruction classes in bits 15:12
    typedef enum logic [3:0] {
        OP_NOP  = 4'h0, OP_ALUI = 4'h1, OP_ALUM = 4'h2, OP_ALUA = 4'h3,
        OP_JMP  = 4'h4, OP_CALL = 4'h5, OP_RET  = 4'h6, OP_INTERRUPT_RETURN = 4'h7,
        OP_SZ   = 4'h8, OP_SNZ  = 4'h9, OP_SIZ  = 4'ha, OP_SDZ  = 4'hb,
        OP_MOVM = 4'hc, OP_MOVA = 4'hd, OP_RS0  = 4'he, OP_RS1  = 4'hf
    } cfe_op_t;

    // ALU operations in bits 11:8
    typedef enum logic [3:0] {
        ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
        ALU_DAA = 4'h4, ALU_AND = 4'h5, ALU_OR  = 4'h6, ALU_XOR = 4'h7,
        ALU_CPL = 4'h8, ALU_RR  = 4'h9, ALU_RRC = 4'ha, ALU_RL  = 4'hb,
        ALU_RLC = 4'hc, ALU_INC = 4'hd, ALU_DEC = 4'he, ALU_PASS = 4'hf
    } cfe_alu_t;
endpackage : cfe_pkg

//--- cfe_pm_model.sv
// Program memory model answering instruction words at the fetch address
`timescale 1ns/1ps
module cfe_pm_model #(
    parameter int AW = 12
) (
    input  wire logic [AW-1:0] addr,
    output logic      [15:0]   rdata
);
    // Word store, loaded by the bench; every cleared word reads as no-op
    logic [15:0] mem [0:(1<<AW)-1];

    // Answer follows the address, valid while the address stands
    assign rdata = mem[addr];
endmodule : cfe_pm_model

//--- cfe_ret_stack.sv
// Hidden return-address stack that drops its oldest entry on overflow
`timescale 1ns/1ps
module cfe_ret_stack #(
    parameter int W     = 12,
    parameter int DEPTH = 6
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         push,
    input  wire logic         pop,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] top,
    output logic              full,
    output logic              empty
);
    logic [W-1:0]             ent_reg [DEPTH];
    logic [$clog2(DEPTH+1)-1:0] lvl_reg;

    // Full and empty from the level pointer
    assign full  = (lvl_reg == ($clog2(DEPTH+1))'(DEPTH));
    assign empty = (lvl_reg == '0);
    assign top   = ent_reg[0];

    // Level pointer, reset to the top of the stack
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            lvl_reg <= '0;
        else if (push && !full)
            lvl_reg <= lvl_reg + 1'b1;
        else if (pop && !push && !empty)
            lvl_reg <= lvl_reg - 1'b1;
    end

    // Entries shift; a push when full loses the deepest entry
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            if (push)
                ent_reg[i] <= (i == 0) ? din : ent_reg[i-1];
            else if (pop && i < DEPTH-1)
                ent_reg[i] <= ent_reg[i+1];
        end
    end
endmodule : cfe_ret_stack
